// File: lsbsc_ctrl.sv
// apb-reached scroll, blink, standby and lcd supply control
// host keeps its own duties: row rewrite after scroll, permit before standby
`timescale 1ns/10ps
`include "lsbsc_defs.svh"

module lsbsc_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic standby_req,
	input wire logic subclk,
	input wire logic line_tick,
	output logic [4:0] display_row,
	output logic [4:0] row_addr,
	output logic [7:0] blink_mask,
	output logic group_8bit,
	output logic display_enable,
	output logic drive_off,
	output logic stepup_clock,
	output logic stepup_active,
	output logic opamp_power,
	output logic opamp_current_limit,
	output logic [3:0] contrast_level,
	output logic in_standby
);

	lsbsc_pkg::lsbsc_state_e st_q;
	lsbsc_pkg::lsbsc_cw1_s cw1_q;
	lsbsc_pkg::lsbsc_cw2_s cw2_q;
	lsbsc_pkg::lsbsc_status_s status;
	logic [3:0] index_q;
	logic [7:0] addr_q;
	logic [4:0] start_q;
	logic [7:0] bmask_q;
	logic [4:0] bfirst_q;
	logic [4:0] blast_q;
	logic [3:0] contrast_q;
	logic [4:0] line_q;
	logic [4:0] line_d;
	logic [4:0] row_d;
	logic [5:0] frame_q;
	logic hidden_q;
	logic frame_end;
	logic access;
	logic wr_done;
	logic wr_data;
	logic enter_stby;
	logic sub_alive;
	logic stepup_run;
	logic [7:0] wbyte;
	logic [31:0] rd_mux;
	logic rd_err;

	function automatic logic idx_mapped(input logic [3:0] idx);
		case (idx)
			`LSBSC_IDX_CW1, `LSBSC_IDX_CW2, `LSBSC_IDX_ADDR, `LSBSC_IDX_START,
			`LSBSC_IDX_BMASK, `LSBSC_IDX_BFIRST, `LSBSC_IDX_BLAST,
			`LSBSC_IDX_CONTRAST: idx_mapped = 1'b1;
			default: idx_mapped = 1'b0;
		endcase
	endfunction : idx_mapped

	function automatic logic [4:0] duty_last(input logic [1:0] duty);
		case (duty)
			`LSBSC_DUTY_16: duty_last = `LSBSC_ROWS_16;
			`LSBSC_DUTY_8: duty_last = `LSBSC_ROWS_8;
			default: duty_last = `LSBSC_ROWS_32;
		endcase
	endfunction : duty_last

	// apb: one wait state, so read data and error come from flops
	assign access = psel & penable & ~pready;
	assign wr_done = psel & penable & pready & pwrite;
	assign wr_data = wr_done & (paddr == `LSBSC_OFF_DATA) & idx_mapped(index_q);
	assign wbyte = pwdata[7:0];
	assign enter_stby = (st_q == lsbsc_pkg::st_active) & standby_req & cw1_q.standby_permit;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= access;
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr)
			`LSBSC_OFF_INDEX: rd_mux = {28'h000_0000, index_q};
			`LSBSC_OFF_DATA:
			begin
				rd_err = ~idx_mapped(index_q);
				case (index_q)
					`LSBSC_IDX_CW1: rd_mux = {24'h00_0000, cw1_q};
					`LSBSC_IDX_CW2: rd_mux = {24'h00_0000, cw2_q};
					`LSBSC_IDX_ADDR: rd_mux = {24'h00_0000, addr_q};
					`LSBSC_IDX_START: rd_mux = {27'h000_0000, start_q};
					`LSBSC_IDX_BMASK: rd_mux = {24'h00_0000, bmask_q};
					`LSBSC_IDX_BFIRST: rd_mux = {27'h000_0000, bfirst_q};
					`LSBSC_IDX_BLAST: rd_mux = {27'h000_0000, blast_q};
					`LSBSC_IDX_CONTRAST: rd_mux = {28'h000_0000, contrast_q};
					default: rd_mux = 32'h0000_0000;
				endcase
			end
			`LSBSC_OFF_STATUS: rd_mux = pwrite ? 32'h0000_0000 : status;
			default: rd_err = 1'b1;
		endcase
		if (pwrite && paddr == `LSBSC_OFF_STATUS)
			rd_err = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (access)
		begin
			prdata <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr <= rd_err;
		end
		else
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			index_q <= 4'h0;
		else if (wr_done && paddr == `LSBSC_OFF_INDEX)
			index_q <= wbyte[3:0];
	end

	// register writes are not gated by standby
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cw1_q <= `LSBSC_BYTE_RST;
			addr_q <= `LSBSC_BYTE_RST;
			start_q <= 5'h00;
			bmask_q <= `LSBSC_BYTE_RST;
			bfirst_q <= 5'h00;
			blast_q <= 5'h00;
			contrast_q <= 4'h0;
		end
		else if (wr_data)
		begin
			case (index_q)
				`LSBSC_IDX_CW1: cw1_q <= wbyte & `LSBSC_CW1_MASK;
				`LSBSC_IDX_ADDR: addr_q <= wbyte;
				`LSBSC_IDX_START: start_q <= 5'(wbyte & `LSBSC_ROW_MASK);
				`LSBSC_IDX_BMASK: bmask_q <= wbyte;
				`LSBSC_IDX_BFIRST: bfirst_q <= 5'(wbyte & `LSBSC_ROW_MASK);
				`LSBSC_IDX_BLAST: blast_q <= 5'(wbyte & `LSBSC_ROW_MASK);
				`LSBSC_IDX_CONTRAST: contrast_q <= 4'(wbyte & `LSBSC_CONTRAST_MASK);
				default: contrast_q <= contrast_q;
			endcase
		end
	end

	// standby entry beats a host write landing in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cw2_q <= `LSBSC_BYTE_RST;
		else if (enter_stby)
		begin
			cw2_q.display_on <= 1'b0;
			cw2_q.opamp_enable <= 1'b0;
		end
		else if (wr_data && index_q == `LSBSC_IDX_CW2)
			cw2_q <= wbyte & `LSBSC_CW2_MASK;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= lsbsc_pkg::st_active;
		else
		begin
			case (st_q)
				lsbsc_pkg::st_active: if (enter_stby) st_q <= lsbsc_pkg::st_standby;
				lsbsc_pkg::st_standby: if (!standby_req) st_q <= lsbsc_pkg::st_active;
				default: st_q <= lsbsc_pkg::st_active;
			endcase
		end
	end

	// scan: line counter wraps at the duty, frame ends on the wrap
	assign frame_end = line_tick & (line_q >= duty_last(cw1_q.duty));
	assign line_d = !line_tick ? line_q : (frame_end ? 5'h00 : line_q + 5'h01);
	assign row_d = (start_q + line_d) & duty_last(cw1_q.duty);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			line_q <= 5'h00;
			display_row <= 5'h00;
		end
		else
		begin
			line_q <= line_d;
			display_row <= row_d;
		end
	end

	// counter cleared while disabled so blinking opens on the visible half
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			frame_q <= 6'h00;
			hidden_q <= 1'b0;
		end
		else if (!cw2_q.blink_enable)
		begin
			frame_q <= 6'h00;
			hidden_q <= 1'b0;
		end
		else if (frame_end)
		begin
			frame_q <= frame_q + 6'h01;
			if (frame_q == `LSBSC_BLINK_LAST_FRAME)
				hidden_q <= ~hidden_q;
		end
	end

	// window compares memory rows, so scrolling carries the blink area along
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			blink_mask <= 8'h00;
		else if (cw2_q.blink_enable && hidden_q && row_d >= bfirst_q && row_d <= blast_q)
			blink_mask <= bmask_q;
		else
			blink_mask <= 8'h00;
	end

	assign stepup_run = cw1_q.stepup_enable & (st_q == lsbsc_pkg::st_active) & ~enter_stby;

	lsbsc_pump u_pump (
		.pclk(pclk),
		.presetn(presetn),
		.subclk(subclk),
		.run(stepup_run),
		.pump_q(stepup_clock),
		.alive_q(sub_alive)
	);

	// supply drops at entry itself, well inside two subclock periods
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stepup_active <= 1'b0;
			opamp_power <= 1'b0;
			opamp_current_limit <= 1'b0;
			drive_off <= 1'b1;
			display_enable <= 1'b0;
			in_standby <= 1'b0;
		end
		else
		begin
			stepup_active <= stepup_run & sub_alive;
			opamp_power <= cw2_q.opamp_enable & ~enter_stby & (st_q == lsbsc_pkg::st_active);
			opamp_current_limit <= cw2_q.opamp_power_save & cw2_q.opamp_enable & ~enter_stby &
				(st_q == lsbsc_pkg::st_active);
			drive_off <= enter_stby | (st_q != lsbsc_pkg::st_active) | ~cw2_q.display_on;
			display_enable <= cw2_q.display_on & ~enter_stby & (st_q == lsbsc_pkg::st_active);
			in_standby <= enter_stby | (st_q == lsbsc_pkg::st_standby & standby_req);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			row_addr <= 5'h00;
			group_8bit <= 1'b0;
			contrast_level <= 4'h0;
		end
		else
		begin
			row_addr <= addr_q[4:0];
			group_8bit <= cw1_q.graphic_layout_select;
			contrast_level <= contrast_q;
		end
	end

	always_comb
	begin
		status = '0;
		status.in_standby = in_standby;
		status.stepup_active = stepup_active;
		status.opamp_power = opamp_power;
		status.blink_hidden = hidden_q;
		status.subclk_alive = sub_alive;
		status.display_row = display_row;
	end

	sequence s_enter;
		enter_stby;
	endsequence

	sequence s_quiet;
		drive_off && !stepup_active && !opamp_power && !display_enable;
	endsequence

	a_index_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_done && paddr == `LSBSC_OFF_INDEX |=> index_q == $past(pwdata[3:0]))
		else $error("index pointer not loaded");

	a_row_field: assert property (@(posedge pclk) disable iff (!presetn)
		wr_data && index_q == `LSBSC_IDX_ADDR |=> ##1 row_addr == $past(pwdata[4:0], 2))
		else $error("row address not from pointer field");

	a_scroll_row: assert property (@(posedge pclk) disable iff (!presetn)
		line_tick && !frame_end && !wr_data |=> display_row ==
		((start_q + line_q) & duty_last(cw1_q.duty)))
		else $error("displayed row not offset by start line");

	a_blink_cols: assert property (@(posedge pclk) disable iff (!presetn)
		(blink_mask & ~$past(bmask_q)) == 8'h00)
		else $error("blink outside column mask");

	a_blink_win: assert property (@(posedge pclk) disable iff (!presetn)
		blink_mask != 8'h00 |-> $past(row_d) >= $past(bfirst_q) && $past(row_d) <= $past(blast_q))
		else $error("blink outside row window");

	a_blink_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!cw2_q.blink_enable |=> blink_mask == 8'h00 && !hidden_q)
		else $error("blink active while disabled");

	a_blink_phase: assert property (@(posedge pclk) disable iff (!presetn)
		hidden_q != $past(hidden_q) && cw2_q.blink_enable |->
		$past(frame_end) && $past(frame_q) == `LSBSC_BLINK_LAST_FRAME)
		else $error("blink phase flipped off a 64 frame boundary");

	a_stby_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		s_enter |=> s_quiet)
		else $error("outputs not quiet in standby");

	a_stby_clear: assert property (@(posedge pclk) disable iff (!presetn)
		s_enter ##1 1'b1 |-> !cw2_q.display_on && !cw2_q.opamp_enable)
		else $error("display on or opamp enable kept over standby");

	a_stby_supply: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == lsbsc_pkg::st_standby |-> !stepup_active && !stepup_clock)
		else $error("supply running in standby");

	a_stby_access: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == lsbsc_pkg::st_standby && wr_data && index_q == `LSBSC_IDX_CONTRAST
		|=> ##1 contrast_level == $past(pwdata[3:0], 2))
		else $error("register write lost in standby");

	a_stepup_gate: assert property (@(posedge pclk) disable iff (!presetn)
		stepup_active |-> $past(cw1_q.stepup_enable) && $past(sub_alive))
		else $error("step-up without enable or subclock");

	a_opamp_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!cw1_q.stepup_enable && !cw2_q.opamp_enable ##1 1'b1 |-> !stepup_active && !opamp_power)
		else $error("supply alive with both enables clear");

	a_power_save: assert property (@(posedge pclk) disable iff (!presetn)
		opamp_current_limit |-> opamp_power)
		else $error("current limit without opamp power");

endmodule : lsbsc_ctrl

// File: lsbsc_defs.svh
// constants for the lcd scroll, blink and standby control block
// assumes a 40 MHz pclk and 12-bit apb byte addresses
`ifndef LSBSC_DEFS_SVH
`define LSBSC_DEFS_SVH

`define LSBSC_OFF_INDEX 12'h000
`define LSBSC_OFF_DATA 12'h004
`define LSBSC_OFF_STATUS 12'h008

`define LSBSC_IDX_CW1 4'h0
`define LSBSC_IDX_CW2 4'h1
`define LSBSC_IDX_ADDR 4'h2
`define LSBSC_IDX_START 4'h5
`define LSBSC_IDX_BMASK 4'h6
`define LSBSC_IDX_BFIRST 4'h8
`define LSBSC_IDX_BLAST 4'h9
`define LSBSC_IDX_CONTRAST 4'hA

`define LSBSC_BYTE_RST 8'h00
`define LSBSC_CW1_MASK 8'hC7
`define LSBSC_CW2_MASK 8'hF0
`define LSBSC_ROW_MASK 8'h1F
`define LSBSC_CONTRAST_MASK 8'h0F

`define LSBSC_DUTY_32 2'h0
`define LSBSC_DUTY_16 2'h1
`define LSBSC_DUTY_8 2'h2
`define LSBSC_ROWS_32 5'h1F
`define LSBSC_ROWS_16 5'h0F
`define LSBSC_ROWS_8 5'h07

`define LSBSC_BLINK_LAST_FRAME 6'h3F

`define LSBSC_CLK_PERIOD_NS 25
`define LSBSC_SUBCLK_LOSS_NS 100000
`define LSBSC_SUBCLK_LOSS_CYC \
	((`LSBSC_SUBCLK_LOSS_NS + `LSBSC_CLK_PERIOD_NS - 1) / `LSBSC_CLK_PERIOD_NS)

`endif

// File: lsbsc_pkg.sv
// types shared by the lcd scroll, blink and standby control block
// assumes nothing beyond the constants header
package lsbsc_pkg;

	typedef enum logic [1:0] {
		st_active = 2'b01,
		st_standby = 2'b10
	} lsbsc_state_e;

	typedef struct packed {
		logic standby_permit;
		logic stepup_enable;
		logic [2:0] rsvd;
		logic graphic_layout_select;
		logic [1:0] duty;
	} lsbsc_cw1_s;

	typedef struct packed {
		logic blink_enable;
		logic display_on;
		logic opamp_enable;
		logic opamp_power_save;
		logic [3:0] rsvd;
	} lsbsc_cw2_s;

	typedef struct packed {
		logic [21:0] rsvd;
		logic in_standby;
		logic stepup_active;
		logic opamp_power;
		logic blink_hidden;
		logic subclk_alive;
		logic [4:0] display_row;
	} lsbsc_status_s;

endpackage : lsbsc_pkg

// File: lsbsc_pump.sv
// subclock watch and step-up pump clock for the lcd supply
// subclk is a slow input taken as synchronous to pclk
`timescale 1ns/10ps
`include "lsbsc_defs.svh"

module lsbsc_pump (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic subclk,
	input wire logic run,
	output logic pump_q,
	output logic alive_q
);

	localparam logic [11:0] LOSS_CYC = 12'(`LSBSC_SUBCLK_LOSS_CYC);

	logic subclk_prev_q;
	logic [11:0] idle_q;
	logic sub_edge;

	assign sub_edge = subclk & ~subclk_prev_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			subclk_prev_q <= 1'b0;
		else
			subclk_prev_q <= subclk;
	end

	// a stopped subclock must read as dead, or the pump would claim to run
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			idle_q <= 12'h000;
			alive_q <= 1'b0;
		end
		else if (sub_edge)
		begin
			idle_q <= 12'h000;
			alive_q <= 1'b1;
		end
		else if (idle_q >= LOSS_CYC - 12'h001)
			alive_q <= 1'b0;
		else
			idle_q <= idle_q + 12'h001;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pump_q <= 1'b0;
		else if (!run)
			pump_q <= 1'b0;
		else if (sub_edge)
			pump_q <= ~pump_q;
	end

endmodule : lsbsc_pump

// File: lsbsc_host.sv
// host cpu model: apb master doing indexed register accesses
// assumes the slave shares pclk and answers with pready
`timescale 1ns/10ps
`include "lsbsc_defs.svh"

module lsbsc_host (
	input wire logic pclk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	logic [31:0] rd_q;
	logic err_q;

	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end

	// request held until pready is seen at a rising edge
	task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle limit here: only the bench watchdog may end a hung wait
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	// index first, then data; index kept by the slave between accesses
	task automatic reg_wr(input logic [3:0] idx, input logic [7:0] val);
		xfer(1'b1, `LSBSC_OFF_INDEX, {28'h0000000, idx});
		xfer(1'b1, `LSBSC_OFF_DATA, {24'h000000, val});
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] idx);
		xfer(1'b1, `LSBSC_OFF_INDEX, {28'h0000000, idx});
		xfer(1'b0, `LSBSC_OFF_DATA, 32'h00000000);
	endtask : reg_rd
endmodule : lsbsc_host

// File: lsbsc_ctrl_tb_top.sv
// self-checking bench for the scroll, blink and standby control block
// assumes the host model drives apb; bench drives line ticks and subclock
`timescale 1ns/10ps
`include "lsbsc_defs.svh"

module lsbsc_ctrl_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic standby_req = 1'b0;
	logic subclk = 1'b0;
	logic sub_run = 1'b1;
	logic line_tick = 1'b0;
	logic [3:0] sub_cnt = 4'h0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [4:0] display_row, row_addr;
	logic [7:0] blink_mask;
	logic [3:0] contrast_level;
	logic group_8bit, display_enable, drive_off, stepup_clock, stepup_active;
	logic opamp_power, opamp_current_limit, in_standby;
	int bad_count = 0;
	int checks = 0;

	always #12.5 pclk = ~pclk;

	// subclock period 20 pclk; stops dead when sub_run is low
	always @(posedge pclk)
	begin
		sub_cnt <= (sub_cnt == 4'h9) ? 4'h0 : sub_cnt + 4'h1;
		if (sub_run && sub_cnt == 4'h9)
			subclk <= ~subclk;
	end

	lsbsc_host lsbsc_host_i (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
		.paddr, .pwdata);

	lsbsc_ctrl lsbsc_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .standby_req, .subclk, .line_tick, .display_row,
		.row_addr, .blink_mask, .group_8bit, .display_enable, .drive_off, .stepup_clock,
		.stepup_active, .opamp_power, .opamp_current_limit, .contrast_level, .in_standby);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tick();
		@(posedge pclk);
		line_tick <= 1'b1;
		@(posedge pclk);
		line_tick <= 1'b0;
		#1;
	endtask : tick

	task automatic t_regs();
		logic [3:0] idx [8] = '{`LSBSC_IDX_CW1, `LSBSC_IDX_CW2, `LSBSC_IDX_ADDR,
			`LSBSC_IDX_START, `LSBSC_IDX_BMASK, `LSBSC_IDX_BFIRST, `LSBSC_IDX_BLAST,
			`LSBSC_IDX_CONTRAST};
		logic [7:0] wv [8] = '{8'h06, 8'hF0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
		logic [7:0] ev [8] = '{8'h06, 8'hF0, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'h1F, 8'h0F};
		for (int i = 0; i < 8; i++)
		begin
			lsbsc_host_i.reg_rd(idx[i]);
			chk(lsbsc_host_i.rd_q, 32'h00000000);
			lsbsc_host_i.reg_wr(idx[i], wv[i]);
			lsbsc_host_i.reg_rd(idx[i]);
			chk(lsbsc_host_i.rd_q, {24'h000000, ev[i]});
		end
		chk({27'h0, row_addr}, 32'h1F);
		chk({28'h0, contrast_level}, 32'hF);
		chk({31'h0, group_8bit}, 32'h1);
		lsbsc_host_i.xfer(1'b0, 12'h00C, 32'h00000000);
		chk({31'h0, lsbsc_host_i.err_q}, 32'h1);
		lsbsc_host_i.xfer(1'b1, `LSBSC_OFF_STATUS, 32'h00000000);
		chk({31'h0, lsbsc_host_i.err_q}, 32'h1);
		lsbsc_host_i.reg_wr(4'h3, 8'h55);
		chk({31'h0, lsbsc_host_i.err_q}, 32'h1);
		for (int i = 0; i < 8; i++)
			lsbsc_host_i.reg_wr(idx[i], 8'h00);
		$display("test regs done");
	endtask : t_regs

	task automatic t_scroll();
		logic [4:0] r;
		lsbsc_host_i.reg_wr(`LSBSC_IDX_CW1, {6'h00, `LSBSC_DUTY_16});
		lsbsc_host_i.reg_wr(`LSBSC_IDX_START, 8'h01);
		tick();
		for (int i = 0; i < 20; i++)
		begin
			r = display_row;
			tick();
			chk({27'h0, display_row}, {27'h0, (r + 5'h01) & `LSBSC_ROWS_16});
		end
		r = display_row;
		lsbsc_host_i.reg_wr(`LSBSC_IDX_START, 8'h05);
		tick();
		chk({27'h0, display_row}, {27'h0, (r + 5'h05) & `LSBSC_ROWS_16});
		// wrapped rows are rewritten only after the new start line is in
		lsbsc_host_i.reg_wr(`LSBSC_IDX_ADDR, 8'h04);
		repeat (2) @(posedge pclk);
		#1 chk({27'h0, row_addr}, 32'h04);
		$display("test scroll done");
	endtask : t_scroll

	task automatic t_blink();
		int hid;
		hid = 0;
		lsbsc_host_i.reg_wr(`LSBSC_IDX_CW1, {5'h00, 1'b1, `LSBSC_DUTY_8});
		lsbsc_host_i.reg_wr(`LSBSC_IDX_BMASK, 8'hA5);
		lsbsc_host_i.reg_wr(`LSBSC_IDX_BFIRST, 8'h02);
		lsbsc_host_i.reg_wr(`LSBSC_IDX_BLAST, 8'h03);
		for (int i = 0; i < 1200; i++)
		begin
			if (i == 16)
				lsbsc_host_i.reg_wr(`LSBSC_IDX_CW2, 8'h80);
			if (i == 700)
				lsbsc_host_i.reg_wr(`LSBSC_IDX_START, 8'h03);
			tick();
			if (blink_mask !== 8'h00)
			begin
				hid++;
				chk({24'h0, blink_mask}, 32'hA5);
			end
			if (i < 20 || display_row < 5'h02 || display_row > 5'h03)
				chk({24'h0, blink_mask}, 32'h00);
		end
		// 64 hidden frames of two rows each, give or take the scroll frame
		chk({31'h0, hid >= 126 && hid <= 130}, 32'h1);
		lsbsc_host_i.reg_wr(`LSBSC_IDX_CW2, 8'h00);
		$display("test blink done");
	endtask : t_blink

	task automatic t_supply();
		logic c;
		int n;
		logic [4:0] r;
		lsbsc_host_i.reg_wr(`LSBSC_IDX_CW1, 8'h40);
		lsbsc_host_i.reg_wr(`LSBSC_IDX_CW2, 8'h70);
		// outputs follow the control word one cycle after the write lands
		repeat (2) @(posedge pclk);
		for (n = 0; n < 100 && stepup_active !== 1'b1; n++)
			@(posedge pclk);
		#1;
		chk({28'h0, stepup_active, opamp_power, opamp_current_limit, display_enable},
			32'hF);
		c = stepup_clock;
		for (n = 0; n < 100 && stepup_clock === c; n++)
			@(posedge pclk);
		chk({31'h0, stepup_clock}, {31'h0, ~c});
		standby_req <= 1'b1;
		repeat (8) @(posedge pclk);
		#1 chk({31'h0, in_standby}, 32'h0);
		lsbsc_host_i.reg_wr(`LSBSC_IDX_CW1, 8'hC0);
		for (n = 0; n < 8 && in_standby !== 1'b1; n++)
			@(posedge pclk);
		#1;
		chk({27'h0, in_standby, drive_off, stepup_active, opamp_power, display_enable},
			32'h18);
		repeat (40) @(posedge pclk);
		c = stepup_clock;
		repeat (80) @(posedge pclk);
		chk({31'h0, stepup_clock}, {31'h0, c});
		lsbsc_host_i.reg_wr(`LSBSC_IDX_CONTRAST, 8'h09);
		lsbsc_host_i.reg_rd(`LSBSC_IDX_CONTRAST);
		chk(lsbsc_host_i.rd_q, 32'h09);
		chk({28'h0, contrast_level}, 32'h9);
		lsbsc_host_i.reg_rd(`LSBSC_IDX_CW2);
		chk(lsbsc_host_i.rd_q, 32'h10);
		lsbsc_host_i.reg_rd(`LSBSC_IDX_CW1);
		chk(lsbsc_host_i.rd_q, 32'hC0);
		lsbsc_host_i.xfer(1'b0, `LSBSC_OFF_STATUS, 32'h00000000);
		chk(lsbsc_host_i.rd_q, {22'h0, 5'h11, display_row});
		standby_req <= 1'b0;
		for (n = 0; n < 8 && in_standby !== 1'b0; n++)
			@(posedge pclk);
		#1 chk({29'h0, in_standby, display_enable, opamp_power}, 32'h0);
		lsbsc_host_i.reg_wr(`LSBSC_IDX_CW1, 8'h00);
		repeat (4) @(posedge pclk);
		#1 chk({30'h0, stepup_active, opamp_power}, 32'h0);
		lsbsc_host_i.reg_wr(`LSBSC_IDX_CW1, 8'h40);
		sub_run <= 1'b0;
		repeat (`LSBSC_SUBCLK_LOSS_CYC + 200) @(posedge pclk);
		#1 chk({31'h0, stepup_active}, 32'h0);
		sub_run <= 1'b1;
		for (n = 0; n < 100 && stepup_active !== 1'b1; n++)
			@(posedge pclk);
		#1 chk({31'h0, stepup_active}, 32'h1);
		// full 1/32 duty scan, crossing the wrap at the last row
		chk({31'h0, group_8bit}, 32'h0);
		r = display_row;
		for (n = 0; n < 40; n++)
		begin
			tick();
			r = r + 5'h01;
			chk({27'h0, display_row}, {27'h0, r});
		end
		$display("test supply done");
	endtask : t_supply

	task automatic summarize();
		$display("checks=%0d mismatches=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	initial
	begin
		repeat (8) @(posedge pclk);
		#1 chk({30'h0, drive_off, in_standby}, 32'h2);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_scroll();
		t_blink();
		t_supply();
		summarize();
	end

	// all tests need about 7400 cycles; this leaves ample slack
	initial
	begin
		repeat (30000) @(posedge pclk);
		bad_count++;
		summarize();
	end
endmodule : lsbsc_ctrl_tb_top
